// ===== hdl/lsr_pkg.sv
package lsr_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_EVENT_FLAG = 8'h21;
   localparam logic [7:0] OFS_VISIBLE_LOW = 8'h22;
   localparam logic [7:0] OFS_VISIBLE_HIGH = 8'h23;
   localparam logic [7:0] OFS_INFRARED_LOW = 8'h24;
   localparam logic [7:0] OFS_INFRARED_HIGH = 8'h25;
   localparam logic [7:0] OFS_PROX_ONE_LOW = 8'h26;
   localparam logic [7:0] OFS_PROX_ONE_HIGH = 8'h27;
   localparam logic [7:0] OFS_RESULT_FIRST = OFS_VISIBLE_LOW;

   // ----------------------------------------------------------------
   // Event flag register fields
   // ----------------------------------------------------------------
   localparam int BIT_AMBIENT_LO = 0;
   localparam int BIT_AMBIENT_HI = 1;
   localparam int BIT_PROX_ONE = 2;
   localparam int BIT_PROX_TWO = 3;
   localparam int BIT_PROX_THREE = 4;
   localparam int BIT_CMD_DONE = 5;
   localparam int FLAG_WIDTH = 6;

   // ----------------------------------------------------------------
   // Reset values and result layout
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_EVENT_FLAG = 8'h00;
   localparam logic [7:0] RST_RESULT_BYTE = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int NUM_RESULTS = 3;
   localparam logic [1:0] SEL_VISIBLE = 2'h0;
   localparam logic [1:0] SEL_INFRARED = 2'h1;
   localparam logic [1:0] SEL_PROX_ONE = 2'h2;

   typedef logic [7:0] lsr_byte_t;
   typedef logic [15:0] lsr_result_t;

endpackage

// ===== hdl/lsr_result_if.sv
`timescale 1ns/10ps
interface lsr_result_if;
   import lsr_pkg::*;
   logic load;
   logic [1:0] load_sel;
   lsr_result_t load_value;
   logic wr_en;
   logic [2:0] wr_idx;
   lsr_byte_t wr_data;
   logic [2:0] rd_idx;
   lsr_byte_t rd_data;

   modport bank
   (
      input load, load_sel, load_value, wr_en, wr_idx, wr_data, rd_idx,
      output rd_data
   );
   modport ctrl
   (
      output load, load_sel, load_value, wr_en, wr_idx, wr_data, rd_idx,
      input rd_data
   );
endinterface

// ===== hdl/lsr_result_bank.sv
`timescale 1ns/10ps
module lsr_result_bank
#(
   parameter int NUM_RESULTS = lsr_pkg::NUM_RESULTS
)
(
   input wire logic clock,
   input wire logic rst_n,
   lsr_result_if.bank rif
);
   import lsr_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (NUM_RESULTS < 1 || NUM_RESULTS > 4)
   begin : g_bad_count
      $error("lsr_result_bank: NUM_RESULTS must be 1 to 4");
   end

   lsr_byte_t byte_reg [2*NUM_RESULTS];

   // ----------------------------------------------------------------
   // Result byte pairs, low byte at the even index
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RESULTS; gi++)
      begin : g_result
         wire logic hit_load;
         wire logic hit_lo;
         wire logic hit_hi;
         assign hit_load = rif.load && (rif.load_sel == 2'(gi));
         assign hit_lo = rif.wr_en && (rif.wr_idx == 3'(2*gi));
         assign hit_hi = rif.wr_en && (rif.wr_idx == 3'(2*gi+1));
         // A fresh measurement wins over a host write in the same cycle
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               byte_reg[2*gi] <= RST_RESULT_BYTE;
               byte_reg[2*gi+1] <= RST_RESULT_BYTE;
            end
            else if (hit_load)
            begin
               byte_reg[2*gi] <= rif.load_value[7:0];
               byte_reg[2*gi+1] <= rif.load_value[15:8];
            end
            else
            begin
               if (hit_lo)
                  byte_reg[2*gi] <= rif.wr_data;
               if (hit_hi)
                  byte_reg[2*gi+1] <= rif.wr_data;
            end
         end
      end
   endgenerate

   assign rif.rd_data = (32'(rif.rd_idx) < 2*NUM_RESULTS) ?
                        byte_reg[rif.rd_idx] : READ_UNMAPPED;

endmodule

// ===== hdl/lsr_status_regs.sv
`timescale 1ns/10ps
module lsr_status_regs
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire lsr_pkg::lsr_byte_t reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [lsr_pkg::FLAG_WIDTH-1:0] event_mask,
   input wire logic cmd_done,
   input wire logic prox_one_evt,
   input wire logic prox_two_evt,
   input wire logic prox_three_evt,
   input wire logic als_evt,
   input wire logic [1:0] als_code,
   input wire logic result_load,
   input wire logic [1:0] result_sel,
   input wire lsr_pkg::lsr_result_t result_value,
   output logic event_irq
);
   import lsr_pkg::*;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic is_result(input logic [7:0] addr);
      is_result = (addr >= OFS_VISIBLE_LOW) && (addr <= OFS_PROX_ONE_HIGH);
   endfunction

   function automatic logic [2:0] result_index(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - OFS_RESULT_FIRST;
      result_index = diff[2:0];
   endfunction

   wire logic hit_flag;
   wire logic hit_result;
   wire logic flag_wr;
   assign hit_flag = (reg_addr == OFS_EVENT_FLAG);
   assign hit_result = is_result(reg_addr);
   assign flag_wr = reg_wr && hit_flag;

   // ----------------------------------------------------------------
   // Result storage
   // ----------------------------------------------------------------
   lsr_result_if rif ();

   assign rif.load = result_load;
   assign rif.load_sel = result_sel;
   assign rif.load_value = result_value;
   assign rif.wr_en = reg_wr && hit_result;
   assign rif.wr_idx = result_index(reg_addr);
   assign rif.wr_data = reg_wdata;
   assign rif.rd_idx = result_index(reg_addr);

   lsr_result_bank #(.NUM_RESULTS(NUM_RESULTS)) u_bank
   (
      .clock(clock),
      .rst_n(rst_n),
      .rif(rif)
   );

   // ----------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------
   logic [FLAG_WIDTH-1:0] flag_reg;
   logic [FLAG_WIDTH-1:0] flag_next;
   wire logic [FLAG_WIDTH-1:0] flag_set;
   wire logic [FLAG_WIDTH-1:0] flag_clr;
   wire logic [1:0] als_field_next;

   // Write one to clear; a set in the same cycle is kept
   assign flag_clr = flag_wr ? reg_wdata[FLAG_WIDTH-1:0] :
                     {FLAG_WIDTH{1'b0}};

   assign flag_set[BIT_CMD_DONE] = cmd_done;
   assign flag_set[BIT_PROX_THREE] = prox_three_evt;
   assign flag_set[BIT_PROX_TWO] = prox_two_evt;
   assign flag_set[BIT_PROX_ONE] = prox_one_evt;
   assign flag_set[BIT_AMBIENT_HI:BIT_AMBIENT_LO] =
          als_evt ? als_code : 2'h0;

   // Ambient field takes the new code whole rather than OR-ing bits,
   // so an old code cannot merge into a meaningless value
   assign als_field_next = als_evt ?
          flag_set[BIT_AMBIENT_HI:BIT_AMBIENT_LO] :
          flag_reg[BIT_AMBIENT_HI:BIT_AMBIENT_LO] &
          ~flag_clr[BIT_AMBIENT_HI:BIT_AMBIENT_LO];

   always_comb
   begin
      flag_next = flag_set[FLAG_WIDTH-1:BIT_PROX_ONE] == 4'h0 ?
                  {flag_reg[FLAG_WIDTH-1:BIT_PROX_ONE] &
                   ~flag_clr[FLAG_WIDTH-1:BIT_PROX_ONE], als_field_next} :
                  {(flag_reg[FLAG_WIDTH-1:BIT_PROX_ONE] &
                    ~flag_clr[FLAG_WIDTH-1:BIT_PROX_ONE]) |
                   flag_set[FLAG_WIDTH-1:BIT_PROX_ONE], als_field_next};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         flag_reg <= RST_EVENT_FLAG[FLAG_WIDTH-1:0];
      else
         flag_reg <= flag_next;
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   // Built from the next flag value so the line moves in the same
   // cycle as the flag register, not one cycle behind it
   wire logic irq_next;
   assign irq_next = |(flag_next & event_mask);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         event_irq <= 1'b0;
      else
         event_irq <= irq_next;
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   wire lsr_byte_t read_mux;
   // Reserved bits 7:6 read as zero
   assign read_mux = hit_flag ? {2'h0, flag_reg} :
                     hit_result ? rif.rd_data : READ_UNMAPPED;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= READ_UNMAPPED;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= read_mux;
      end
   end

endmodule

// ===== tb/lsr_chk.sv
`timescale 1ns/10ps
module lsr_chk
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [lsr_pkg::FLAG_WIDTH-1:0] event_mask,
   input wire logic cmd_done,
   input wire logic prox_one_evt,
   input wire logic als_evt,
   input wire logic [1:0] als_code,
   input wire logic event_irq
);
   import lsr_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire unmapped = (reg_addr < OFS_EVENT_FLAG) ||
                   (reg_addr > OFS_PROX_ONE_HIGH);
   // Only the flag register has reserved bits; result bytes use all 8
   wire flag_read = reg_rd && (reg_addr == OFS_EVENT_FLAG);
   sequence s_prox_enabled;
      prox_one_evt && event_mask[BIT_PROX_ONE];
   endsequence
   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered one cycle later");
   chk_rvalid_one_cycle: assert property (
      !reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");
   chk_unmapped_zero: assert property (
      reg_rd && unmapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_reserved_zero: assert property (
      flag_read |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved bits not zero");
   chk_irq_prox: assert property (s_prox_enabled |=> event_irq)
      else $error("enabled proximity event gave no interrupt");
   chk_irq_cmd: assert property (
      cmd_done && event_mask[BIT_CMD_DONE] |=> event_irq)
      else $error("enabled command event gave no interrupt");
   chk_irq_ambient: assert property (
      als_evt && |(als_code & event_mask[1:0]) |=> event_irq)
      else $error("enabled ambient code gave no interrupt");
   chk_irq_masked: assert property (
      event_mask == 6'h00 |=> !event_irq)
      else $error("interrupt with all sources masked");
   chk_rdata_hold: assert property (
      !reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved without a read");
endmodule
bind lsr_status_regs lsr_chk u_lsr_chk (.clock, .rst_n, .reg_addr, .reg_rd,
   .reg_rdata, .reg_rvalid, .event_mask, .cmd_done, .prox_one_evt, .als_evt,
   .als_code, .event_irq);

// ===== tb/lsr_host.sv
`timescale 1ns/10ps
module lsr_host
(
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output lsr_pkg::lsr_byte_t reg_wdata
);
   import lsr_pkg::*;
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // Released bus shows inverted values so stale data is never trusted
   task automatic wr(input logic [7:0] a, input lsr_byte_t d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // Result is taken right after the answer, before any new load
   task automatic rd(input logic [7:0] a, output lsr_byte_t d, output logic v);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~a;
      v = reg_rvalid;
      d = reg_rdata;
   endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import lsr_pkg::*;
   logic clock, rst_n, reg_wr, reg_rd, reg_rvalid, event_irq, result_load;
   logic cmd_done, prox_one_evt, prox_two_evt, prox_three_evt, als_evt;
   logic [7:0] reg_addr, reg_rdata;
   lsr_byte_t reg_wdata;
   logic [5:0] event_mask;
   logic [1:0] als_code, result_sel;
   lsr_result_t result_value;
   int mismatches = 0;
   int samples_checked = 0;
   lsr_status_regs u_lsr_status_regs (.clock, .rst_n, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .event_mask, .cmd_done,
      .prox_one_evt, .prox_two_evt, .prox_three_evt, .als_evt, .als_code,
      .result_load, .result_sel, .result_value, .event_irq);
   lsr_host u_lsr_host (.clock, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata);
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      lsr_byte_t d;
      logic v;
      u_lsr_host.rd(a, d, v);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask
   // Bit positions follow the flag register: 5 cmd, 4..2 prox, 0 ambient
   task automatic evt(input logic [5:0] e, input logic [1:0] c);
      @(negedge clock);
      {cmd_done, prox_three_evt, prox_two_evt, prox_one_evt} = e[5:2];
      als_evt = e[0];
      als_code = c;
      @(negedge clock);
      {cmd_done, prox_three_evt, prox_two_evt, prox_one_evt, als_evt} = 5'h00;
   endtask
   task automatic load(input logic [1:0] s, input lsr_result_t v);
      @(negedge clock);
      result_sel = s;
      result_value = v;
      result_load = 1'b1;
      @(negedge clock);
      result_load = 1'b0;
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #200000;
      mismatches++;
      print_verdict();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      {cmd_done, prox_three_evt, prox_two_evt, prox_one_evt, als_evt} = 5'h00;
      {result_load, result_sel, als_code, result_value} = 21'h000000;
      event_mask = 6'h04;
      repeat (5) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      for (int i = 0; i < 7; i++) rdc(8'h21 + 8'(i), 8'h00);
      rdc(8'h30, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         load(2'(i), {8'hA0 + 8'(i), 8'h50 + 8'(i)});
         rdc(8'h22 + 8'(2 * i), 8'h50 + 8'(i));
         rdc(8'h23 + 8'(2 * i), 8'hA0 + 8'(i));
      end
      u_lsr_host.wr(8'h22, 8'h3C);
      rdc(8'h22, 8'h3C);
      evt(6'h04, 2'h0);
      check({7'h00, event_irq}, 8'h01);
      rdc(8'h21, 8'h04);
      event_mask = 6'h00;
      repeat (2) @(negedge clock);
      check({7'h00, event_irq}, 8'h00);
      event_mask = 6'h3F;
      evt(6'h39, 2'h2);
      rdc(8'h21, 8'h3E);
      evt(6'h01, 2'h1);
      rdc(8'h21, 8'h3D);
      u_lsr_host.wr(8'h21, 8'h3F);
      check({7'h00, event_irq}, 8'h00);
      rdc(8'h21, 8'h00);
      // Event and clear in one cycle: the event must win
      fork
         u_lsr_host.wr(8'h21, 8'h07);
         evt(6'h05, 2'h3);
      join
      check({7'h00, event_irq}, 8'h01);
      rdc(8'h21, 8'h07);
      // A fresh measurement beats a host write to the same result
      fork
         load(2'h1, 16'hABCD);
         u_lsr_host.wr(8'h24, 8'h11);
      join
      rdc(8'h24, 8'hCD);
      rdc(8'h25, 8'hAB);
      u_lsr_host.wr(8'h28, 8'h55);
      rdc(8'h28, 8'h00);
      print_verdict();
   end
endmodule
